// ### shared/blscfg_pkg.sv
package blscfg_pkg;
    // register offsets on the internal register port
    localparam logic [7:0] SYNC_DITHER_BOOST_CFG_ADDR = 8'ha5;
    localparam logic [7:0] PLL_DIVIDER_HIGH_ADDR = 8'ha6;
    localparam logic [7:0] PLL_DIVIDER_LOW_FREQ_HYST_ADDR = 8'ha7;
    // field positions
    localparam int SYNC_EN_BIT = 7;
    localparam int DITHER_MSB = 6;
    localparam int DITHER_LSB = 5;
    localparam int BOOST_MSB = 4;
    localparam int BOOST_LSB = 0;
    localparam int DIV_LOW_MSB = 7;
    localparam int DIV_LOW_LSB = 3;
    localparam int FREQ_RES_BIT = 2;
    localparam int HYST_MSB = 1;
    localparam int HYST_LSB = 0;
    localparam int DIV_W = 13;
    // boost voltage mapping, volts
    localparam logic [5:0] BOOST_BASE_V = 6'h0a;
    localparam logic [5:0] BOOST_MAX_V = 6'h28;
    // loop frequency per resolution code, MHz
    localparam logic [5:0] LOOP_MHZ_0 = 6'h05;
    localparam logic [5:0] LOOP_MHZ_1 = 6'h0a;
    localparam logic [5:0] LOOP_MHZ_2 = 6'h14;
    localparam logic [5:0] LOOP_MHZ_3 = 6'h28;
    // hysteresis resolution in bits per code
    localparam logic [3:0] HYST_RES_1 = 4'hb;
    localparam logic [3:0] HYST_RES_2 = 4'ha;
    localparam logic [3:0] HYST_RES_3 = 4'h8;
endpackage

// ### tb/blscfg_host.sv
`timescale 1ns/100ps
`default_nettype none
module blscfg_host;
    // loop MHz over constant times sync Hz, rounded; 0 if over 13 bits
    function automatic logic [12:0] div(input int mhz, input int hz);
        int k = (mhz == 5) ? 26 : (mhz == 10) ? 50 : (mhz == 20) ? 98 : 196;
        int d = (mhz * 1000000 + k * hz / 2) / (k * hz);
        return (d < 8192) ? d[12:0] : 13'h0;
    endfunction
endmodule
`default_nettype wire

// ### tb/blscfg_regs_sva.sv
`timescale 1ns/100ps
`default_nettype none
module blscfg_regs_sva
    import blscfg_pkg::*;
(
    input wire logic core_clk_i, rst_i, nvm_load_i, reg_wr_i, sync_i,
    input wire logic loaded_o, loop_sync_o, adaptive_en_i, boost_fixed_o,
    input wire logic dimming_active_i,
    input wire logic [1:0] dimming_resolution_i, dither_bits_o,
    input wire logic [7:0] reg_addr_i, reg_wdata_i,
    input wire logic [5:0] loop_mhz_o, boost_target_volts_o,
    input wire logic [DIV_W-1:0] loop_divider_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    a_sync_gate:
    assert property (loop_sync_o |-> sync_i && loaded_o) else $error("sync");
    a_div_unused:
    assert property (loaded_o && sync_i && !loop_sync_o |-> loop_divider_o == 0)
        else $error("divider");
    a_dither_gate:
    assert property (!dimming_active_i |-> dither_bits_o == 2'h0) else $error("dither");
    a_boost_range:
    assert property (boost_target_volts_o inside {[6'h0a:6'h28]}) else $error("boost");
    a_boost_mode:
    assert property (boost_fixed_o == !adaptive_en_i) else $error("mode");
    a_loop_freq:
    assert property (loop_mhz_o == (6'h05 << dimming_resolution_i)) else $error("loop");
    a_write_now:
    assert property (reg_wr_i && loaded_o && !nvm_load_i && reg_addr_i == 8'ha6 |=>
        loop_divider_o == 0 || loop_divider_o[12:5] == $past(reg_wdata_i))
        else $error("write");
    a_load_done:
    assert property (nvm_load_i |=> loaded_o) else $error("load");
endmodule
bind blscfg_regs blscfg_regs_sva u_sva (.*);
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import blscfg_pkg::*;
    logic core_clk_i = 0, rst_i = 1, nvm_load_i = 0, reg_wr_i = 0, reg_rd_i = 0;
    logic adaptive_en_i = 0, sync_i = 1, dimming_active_i = 0;
    logic [1:0] dimming_resolution_i = 0, dither_bits_o;
    logic [7:0] nvm_cfg_i = 8'h9c, nvm_div_high_i = 8'h3a, nvm_div_low_i = 8'h51;
    logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o;
    logic reg_hit_o, loaded_o, loop_sync_o, boost_fixed_o;
    logic freq_resistor_select_o, hyst_en_o;
    logic [DIV_W-1:0] loop_divider_o;
    logic [5:0] loop_mhz_o, boost_target_volts_o;
    logic [3:0] hyst_res_o;
    logic [3:0] hy [4] = '{4'h0, 4'hb, 4'ha, 4'h8};
    logic [12:0] d;
    int bad_count = 0, n_compared = 0, cycles = 0;
    blscfg_regs dut (.*);
    blscfg_host host ();
    initial forever #20 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) if (++cycles > 3000) stop_test(1);
    task automatic stop_test(input int t);
        bad_count += t;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [12:0] s, e);
        n_compared++;
        bad_count += (s !== e);
        if (s !== e)
            $display("[FAIL] %s expected %h seen %h", n, e, s);
    endtask
    task automatic wr(input logic [7:0] a, w);
        {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, w};
        @(posedge core_clk_i) #2 reg_wr_i = 0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        {reg_rd_i, reg_addr_i} = {1'b1, a};
        @(posedge core_clk_i) #2 reg_rd_i = 0;
        chk("rdata", reg_rdata_o, e);
        chk("hit", reg_hit_o, a inside {8'ha5, 8'ha6, 8'ha7});
    endtask
    initial
    begin
        repeat (16) @(posedge core_clk_i);
        #2 rst_i = 0;
        // dropped: store not yet loaded
        wr(8'ha6, 8'hff);
        nvm_load_i = 1;
        @(posedge core_clk_i) #2 nvm_load_i = 0;
        chk("loaded", loaded_o, 1'b1);
        rd(8'ha5, 8'h9c);
        rd(8'ha6, 8'h3a);
        rd(8'h10, 8'h00);
        d = host.div(5, 60);
        wr(8'ha6, d[12:5]);
        for (int i = 0; i < 4; i++)
        begin
            dimming_resolution_i = i[1:0];
            wr(8'ha7, {d[4:0], i[0], i[1:0]});
            chk("hyst", hyst_res_o, hy[i]);
            chk("hyst_en", hyst_en_o, i != 0);
            chk("fres", freq_resistor_select_o, i[0]);
            chk("mhz", loop_mhz_o, 6'h05 << i);
        end
        wr(8'ha5, 8'h1c);
        chk("div", loop_divider_o, 13'h0);
        chk("sync", loop_sync_o, 1'b0);
        wr(8'ha5, 8'h80);
        chk("div", loop_divider_o, 13'hc85);
        chk("sync", loop_sync_o, 1'b1);
        sync_i = 0;
        @(posedge core_clk_i) #2 chk("sync", loop_sync_o, 1'b0);
        for (int c = 0; c < 32; c++)
        begin
            {adaptive_en_i, dimming_active_i} = {c[0], c[1]};
            wr(8'ha5, {3'b011, c[4:0]});
            chk("volts", boost_target_volts_o, c > 29 ? 40 : 10 + c);
            chk("dither", dither_bits_o, c[1] ? 2'h3 : 2'h0);
            chk("fixed", boost_fixed_o, !c[0]);
        end
        stop_test(0);
    end
endmodule
`default_nettype wire

// ### verilog/blscfg_decode.sv
`timescale 1ns/100ps
`default_nettype none
module blscfg_decode
(
    // stored bytes
    input wire logic [7:0] cfg_byte_i,
    input wire logic [7:0] div_high_i,
    input wire logic [7:0] div_low_i,
    // decoded controls
    output logic sync_en_o,
    output logic [1:0] dither_bits_o,
    output logic [5:0] boost_volts_o,
    output logic [blscfg_pkg::DIV_W-1:0] divider_o,
    output logic freq_resistor_select_o,
    output logic hyst_en_o,
    output logic [3:0] hyst_res_o
);
    import blscfg_pkg::*;

    wire logic [4:0] boost_voltage_code;
    wire logic [1:0] hyst_code;

    assign sync_en_o = cfg_byte_i[SYNC_EN_BIT];
    assign dither_bits_o = cfg_byte_i[DITHER_MSB:DITHER_LSB];
    assign boost_voltage_code = cfg_byte_i[BOOST_MSB:BOOST_LSB];
    // top two codes both clamp to the maximum
    assign boost_volts_o = (boost_voltage_code >= 5'h1e) ? BOOST_MAX_V
        : BOOST_BASE_V + {1'b0, boost_voltage_code};
    assign divider_o = {div_high_i, div_low_i[DIV_LOW_MSB:DIV_LOW_LSB]};
    assign freq_resistor_select_o = div_low_i[FREQ_RES_BIT];
    assign hyst_code = div_low_i[HYST_MSB:HYST_LSB];
    assign hyst_en_o = hyst_code != 2'h0;
    assign hyst_res_o = (hyst_code == 2'h1) ? HYST_RES_1
        : (hyst_code == 2'h2) ? HYST_RES_2
        : (hyst_code == 2'h3) ? HYST_RES_3 : 4'h0;
endmodule
`default_nettype wire

// ### verilog/blscfg_regs.sv
`timescale 1ns/100ps
`default_nettype none
module blscfg_regs
#(
    // byte-wide fields are fixed by the register layout
    parameter int ADDR_W = 8,
    parameter int DATA_W = 8
)
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // start-up load from non-volatile store
    input wire logic nvm_load_i,
    input wire logic [DATA_W-1:0] nvm_cfg_i,
    input wire logic [DATA_W-1:0] nvm_div_high_i,
    input wire logic [DATA_W-1:0] nvm_div_low_i,
    // register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    output logic reg_hit_o,
    // related inputs from other groups
    input wire logic adaptive_en_i,
    input wire logic [1:0] dimming_resolution_i,
    input wire logic sync_i,
    input wire logic dimming_active_i,
    // decoded controls
    output logic loaded_o,
    output logic loop_sync_o,
    output logic [blscfg_pkg::DIV_W-1:0] loop_divider_o,
    output logic [5:0] loop_mhz_o,
    output logic [1:0] dither_bits_o,
    output logic [5:0] boost_target_volts_o,
    output logic boost_fixed_o,
    output logic freq_resistor_select_o,
    output logic hyst_en_o,
    output logic [3:0] hyst_res_o
);
    import blscfg_pkg::*;

    // elaboration check: fields are decoded as whole bytes
    generate
        if (ADDR_W != 8 || DATA_W != 8)
        begin
            $error("register port must be eight bits wide");
        end
    endgenerate

    // one register offset against the port address
    function automatic logic addr_match
    (
        input logic [ADDR_W-1:0] addr,
        input logic [7:0] offset
    );
        return addr == offset;
    endfunction

    // loop frequency chosen by the resolution field
    function automatic logic [5:0] loop_mhz(input logic [1:0] res);
        logic [5:0] mhz;
        unique case (res)
            2'h0: mhz = LOOP_MHZ_0;
            2'h1: mhz = LOOP_MHZ_1;
            2'h2: mhz = LOOP_MHZ_2;
            2'h3: mhz = LOOP_MHZ_3;
        endcase
        return mhz;
    endfunction

    // stored byte shown for a matching offset, zero elsewhere
    function automatic logic [7:0] read_mux
    (
        input logic sel_cfg,
        input logic sel_high,
        input logic sel_low,
        input logic [7:0] cfg,
        input logic [7:0] high,
        input logic [7:0] low
    );
        logic [7:0] value;
        value = 8'h00;
        if (sel_cfg)
            value = cfg;
        else if (sel_high)
            value = high;
        else if (sel_low)
            value = low;
        return value;
    endfunction

    logic [7:0] cfg_byte;
    logic [7:0] div_high;
    logic [7:0] div_low;
    logic loaded;
    logic [7:0] rdata;
    wire logic sync_en;
    wire logic [1:0] dither_field;
    wire logic [DIV_W-1:0] divider;
    wire logic hit_cfg;
    wire logic hit_high;
    wire logic hit_low;
    wire logic hit_any;
    wire logic wr_take;
    wire logic wr_cfg;
    wire logic wr_high;
    wire logic wr_low;
    wire logic sync_active;
    wire logic [7:0] next_rdata;

    assign hit_cfg = addr_match(reg_addr_i, SYNC_DITHER_BOOST_CFG_ADDR);
    assign hit_high = addr_match(reg_addr_i, PLL_DIVIDER_HIGH_ADDR);
    assign hit_low = addr_match(reg_addr_i, PLL_DIVIDER_LOW_FREQ_HYST_ADDR);
    assign hit_any = hit_cfg | hit_high | hit_low;
    // host writes are dropped until the start-up copy is done
    // and while a copy is under way, so the copy always wins
    assign wr_take = reg_wr_i && loaded && !nvm_load_i;
    assign wr_cfg = wr_take && hit_cfg;
    assign wr_high = wr_take && hit_high;
    assign wr_low = wr_take && hit_low;
    assign next_rdata = read_mux(hit_cfg, hit_high, hit_low,
        cfg_byte, div_high, div_low);

    // configuration byte: sync, dither and boost code
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            cfg_byte <= 8'h00;
        else if (nvm_load_i)
            cfg_byte <= nvm_cfg_i;
        else if (wr_cfg)
            cfg_byte <= reg_wdata_i;
    end

    // upper divider byte
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            div_high <= 8'h00;
        else if (nvm_load_i)
            div_high <= nvm_div_high_i;
        else if (wr_high)
            div_high <= reg_wdata_i;
    end

    // lower divider bits, frequency source and hysteresis
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            div_low <= 8'h00;
        else if (nvm_load_i)
            div_low <= nvm_div_low_i;
        else if (wr_low)
            div_low <= reg_wdata_i;
    end

    // set once the stored contents have been copied in
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            loaded <= 1'b0;
        else if (nvm_load_i)
            loaded <= 1'b1;
    end

    // read data is registered and holds until the next read
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            rdata <= 8'h00;
        else if (reg_rd_i)
            rdata <= next_rdata;
    end

    assign reg_rdata_o = rdata;
    assign reg_hit_o = hit_any;
    assign loaded_o = loaded;

    blscfg_decode u_decode
    (
        .cfg_byte_i(cfg_byte),
        .div_high_i(div_high),
        .div_low_i(div_low),
        .sync_en_o(sync_en),
        .dither_bits_o(dither_field),
        .boost_volts_o(boost_target_volts_o),
        .divider_o(divider),
        .freq_resistor_select_o(freq_resistor_select_o),
        .hyst_en_o(hyst_en_o),
        .hyst_res_o(hyst_res_o)
    );

    // sync and divider held inactive until the start-up copy is done
    assign sync_active = loaded && sync_en;
    assign loop_sync_o = sync_active && sync_i;
    // divider is masked while sync is disabled or before load, but stays visible to the loop while sync_i is low
    assign loop_divider_o = sync_active ? divider
        : {DIV_W{1'b0}};
    assign loop_mhz_o = loop_mhz(dimming_resolution_i);
    // dither applies only during transitions
    assign dither_bits_o = dimming_active_i ? dither_field : 2'h0;
    assign boost_fixed_o = !adaptive_en_i;
endmodule
`default_nettype wire
